// >>> ccs_pkg.sv
package ccs_pkg;

	// Source clock selection codes
	localparam logic [3:0] SEL_EXT    = 4'h0;
	localparam logic [3:0] SEL_RC     = 4'h2;
	localparam logic [3:0] SEL_LF128  = 4'h3;
	localparam logic [3:0] SEL_LFX_LO = 4'h6;
	localparam logic [3:0] SEL_LFX_HI = 4'h7;

	// Start-up time codes
	localparam logic [1:0] DLY_SHORT    = 2'h0;
	localparam logic [1:0] DLY_MID      = 2'h1;
	localparam logic [1:0] DLY_LONG     = 2'h2;
	localparam logic [1:0] DLY_RESERVED = 2'h3;

	// Shipped configuration
	localparam logic [3:0] SHIP_SEL = SEL_RC;
	localparam logic [1:0] SHIP_DLY = DLY_LONG;
	localparam logic       SHIP_DIV8  = 1'b1;

	// Source cycle counts
	localparam logic [15:0] CK_RST_LFX  = 16'h0004;
	localparam logic [15:0] CK_RST_INT  = 16'h000E;
	localparam logic [15:0] CK_WAKE_1K  = 16'h0400;
	localparam logic [15:0] CK_WAKE_32K = 16'h8000;
	localparam logic [15:0] CK_WAKE_6   = 16'h0006;

	// Millisecond time-outs, in microseconds
	localparam int T_4P1MS_US = 4100;
	localparam int T_65MS_US  = 65000;
	localparam int T_4MS_US   = 4000;
	localparam int T_64MS_US  = 64000;
	// Watchdog oscillator period in ns, plain default
	localparam int WDOG_PERIOD_NS = 7813;
	localparam int CLK_PERIOD_NS  = 10;

	// Least time rounds up to whole watchdog ticks
	function automatic logic [15:0] us_to_ticks(input int us);
		int t;
		t = (us * 1000 + WDOG_PERIOD_NS - 1) / WDOG_PERIOD_NS;
		if (t < 1)
			t = 1;
		return t[15:0];
	endfunction

	localparam logic [15:0] TICKS_4P1MS = us_to_ticks(T_4P1MS_US);
	localparam logic [15:0] TICKS_65MS  = us_to_ticks(T_65MS_US);
	localparam logic [15:0] TICKS_4MS   = us_to_ticks(T_4MS_US);
	localparam logic [15:0] TICKS_64MS  = us_to_ticks(T_64MS_US);

	// Register byte offsets
	localparam logic [3:0] OFF_TRIM   = 4'h0;
	localparam logic [3:0] OFF_DIV    = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [3:0] OFF_CTRL   = 4'hC;

	// Divider codes after reset
	localparam logic [3:0] DIV_BY1 = 4'h0;
	localparam logic [3:0] DIV_BY8 = 4'h3;

	typedef enum {SRC_EXT, SRC_RC, SRC_LF128, SRC_LFXTAL, SRC_NONE} ccs_src_t;
	typedef enum {ST_POR_CK, ST_POR_MS, ST_RUN, ST_SLEEP, ST_WAKE, ST_HALT} ccs_state_t;

endpackage

// >>> ccs_pin_edge.sv
`timescale 1ns/1ps
module ccs_pin_edge
	import ccs_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Pin and edge pulse
	input  wire logic pin,
	output logic      rise
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Only the second stage reads the first; the chain runs through reset so no false edge follows release
	always_ff @(posedge clk) begin
		s1_q <= pin;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			rise <= 1'b0;
		else
			rise <= s2_q & ~s3_q;
	end

endmodule // ccs_pin_edge

// >>> ccs_tick_count.sv
`timescale 1ns/1ps
module ccs_tick_count
	import ccs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Control
	input  wire logic        clear,
	input  wire logic        tick,
	input  wire logic [15:0] target,
	// Status
	output logic      [15:0] count,
	output logic             done
);

	// Saturates at target so a late state change cannot wrap it
	always_ff @(posedge clk) begin
		if (!rstn || clear)
			count <= 16'h0000;
		else if (tick && count != target)
			count <= count + 16'h0001;
	end

	assign done = (count == target);

endmodule // ccs_tick_count

// >>> ccs_clock_select.sv
`timescale 1ns/1ps
module ccs_clock_select
	import ccs_pkg::*;
#(
	parameter logic [15:0] MS_4P1_TICKS = TICKS_4P1MS,
	parameter logic [15:0] MS_65_TICKS  = TICKS_65MS,
	parameter logic [15:0] MS_4_TICKS   = TICKS_4MS,
	parameter logic [15:0] MS_64_TICKS  = TICKS_64MS
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Nonvolatile configuration
	input  wire logic        fuse_valid,
	input  wire logic [3:0]  clock_source_select_fuses,
	input  wire logic [1:0]  startup_time_fuses,
	input  wire logic        divide_by_eight_fuse,
	input  wire logic        reset_pin_disable_fuse,
	input  wire logic [7:0]  factory_trim,
	// Oscillator, clock and wake event pins
	input  wire logic        crystal_input_pin,
	input  wire logic        rc_osc_clk,
	input  wire logic        lf128_osc_clk,
	input  wire logic        wdog_osc_clk,
	input  wire logic        wake_event,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Clock system outputs
	output logic             sys_reset_n,
	output logic             wake_hold,
	output logic      [2:0]  src_sel,
	output logic      [7:0]  rc_trim,
	output logic      [3:0]  div_code,
	output logic             cfg_error
);

	logic [3:0]  srcsel_q;
	logic [1:0]  dly_q;
	logic        rstdis_q;
	logic [7:0]  trim_q;
	logic [3:0]  div_q;
	logic        ack_q;
	logic        sleep_q;
	logic [31:0] rdata_q;
	logic        rst_out_q;
	logic        hold_q;
	ccs_src_t   src_q;
	ccs_state_t state_q;

	logic        xtal_rise;
	logic        rc_rise;
	logic        lf128_rise;
	logic        wd_rise;
	logic        wake_rise;
	logic        src_tick;
	logic [15:0] ck_target;
	logic [15:0] wake_target;
	logic [15:0] ms_target;
	logic [15:0] src_target;
	logic [15:0] src_count;
	logic [15:0] wd_count;
	logic        src_done;
	logic        wd_done;
	logic        err;
	logic        wr_ok;
	logic        rd_ok;

	// Configuration is latched while reset is low; unprogrammed array falls back to shipped values
	always_ff @(posedge clk) begin
		if (!rstn) begin
			srcsel_q <= fuse_valid ? clock_source_select_fuses : SHIP_SEL;
			dly_q    <= fuse_valid ? startup_time_fuses : SHIP_DLY;
			rstdis_q <= fuse_valid & reset_pin_disable_fuse;
		end
	end

	// Pin synchronisers with edge detect
	ccs_pin_edge u_xtal (
		.clk  (clk),
		.rstn (rstn),
		.pin  (crystal_input_pin),
		.rise (xtal_rise)
	);
	ccs_pin_edge u_rc (
		.clk  (clk),
		.rstn (rstn),
		.pin  (rc_osc_clk),
		.rise (rc_rise)
	);
	ccs_pin_edge u_lf128 (
		.clk  (clk),
		.rstn (rstn),
		.pin  (lf128_osc_clk),
		.rise (lf128_rise)
	);
	ccs_pin_edge u_wd (
		.clk  (clk),
		.rstn (rstn),
		.pin  (wdog_osc_clk),
		.rise (wd_rise)
	);
	ccs_pin_edge u_wake (
		.clk  (clk),
		.rstn (rstn),
		.pin  (wake_event),
		.rise (wake_rise)
	);

	// Source decode
	always_comb begin
		unique case (srcsel_q)
			SEL_EXT:    src_q = SRC_EXT;
			SEL_RC:     src_q = SRC_RC;
			SEL_LF128:  src_q = SRC_LF128;
			SEL_LFX_LO,
			SEL_LFX_HI: src_q = SRC_LFXTAL;
			default:      src_q = SRC_NONE;
		endcase
	end

	// Crystal and external clock share the input pin
	always_comb begin
		unique case (src_q)
			SRC_EXT,
			SRC_LFXTAL: src_tick = xtal_rise;
			SRC_RC:     src_tick = rc_rise;
			SRC_LF128:  src_tick = lf128_rise;
			SRC_NONE:   src_tick = 1'b0;
		endcase
	end

	// Cycle counts per source
	always_comb begin
		if (src_q == SRC_LFXTAL) begin
			ck_target   = CK_RST_LFX;
			wake_target = srcsel_q[0] ? CK_WAKE_32K : CK_WAKE_1K;
		end else begin
			ck_target   = CK_RST_INT;
			wake_target = CK_WAKE_6;
		end
	end

	// Millisecond time-out per source and start-up code
	always_comb begin
		ms_target = 16'h0000;
		unique case (dly_q)
			DLY_SHORT: begin
				if (rstdis_q && (src_q == SRC_RC || src_q == SRC_LF128))
					ms_target = MS_4P1_TICKS;
			end
			DLY_MID:  ms_target = (src_q == SRC_LF128) ? MS_4_TICKS : MS_4P1_TICKS;
			DLY_LONG: ms_target = (src_q == SRC_LF128) ? MS_64_TICKS : MS_65_TICKS;
			DLY_RESERVED: ms_target = 16'h0000;
		endcase
	end

	// Reserved or unknown codes keep the device in reset rather than guess a delay
	assign err = (src_q == SRC_NONE) || (dly_q == DLY_RESERVED);

	assign src_target = (state_q == ST_WAKE) ? wake_target : ck_target;

	ccs_tick_count u_src_cnt (
		.clk    (clk),
		.rstn   (rstn),
		.clear  (state_q != ST_POR_CK && state_q != ST_WAKE),
		.tick   (src_tick),
		.target (src_target),
		.count  (src_count),
		.done   (src_done)
	);

	// Time-out runs on the watchdog oscillator whatever the system source
	ccs_tick_count u_wd_cnt (
		.clk    (clk),
		.rstn   (rstn),
		.clear  (state_q != ST_POR_MS),
		.tick   (wd_rise),
		.target (ms_target),
		.count  (wd_count),
		.done   (wd_done)
	);

	// Start-up sequencer
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= ST_POR_CK;
		end else begin
			unique case (state_q)
				ST_POR_CK: begin
					if (err)
						state_q <= ST_HALT;
					else if (src_done)
						state_q <= (ms_target == 16'h0000) ? ST_RUN : ST_POR_MS;
				end
				ST_POR_MS: begin
					if (wd_done)
						state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (sleep_q)
						state_q <= ST_SLEEP;
				end
				ST_SLEEP: begin
					if (wake_rise)
						state_q <= ST_WAKE;
				end
				ST_WAKE: begin
					if (src_done)
						state_q <= ST_RUN;
				end
				ST_HALT: state_q <= ST_HALT;
			endcase
		end
	end

	// Registered reset and wake-hold outputs
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rst_out_q <= 1'b0;
			hold_q    <= 1'b0;
		end else begin
			rst_out_q <= (state_q != ST_POR_CK && state_q != ST_POR_MS && state_q != ST_HALT);
			hold_q    <= (state_q == ST_SLEEP || state_q == ST_WAKE);
		end
	end

	// Bus handshake: one wait cycle per access
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	// Writes land on the edge where waitrequest is low, as the master sees it
	assign wr_ok = avs_write & ack_q;
	assign rd_ok = avs_read & ~ack_q;

	always_ff @(posedge clk) begin
		if (!rstn)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read | avs_write) & ~ack_q;
	end

	// Trim register
	always_ff @(posedge clk) begin
		if (!rstn)
			trim_q <= factory_trim;
		else if (wr_ok && avs_address == OFF_TRIM && avs_byteenable[0])
			trim_q <= avs_writedata[7:0];
	end

	// Divider code
	always_ff @(posedge clk) begin
		if (!rstn)
			div_q <= (fuse_valid ? divide_by_eight_fuse : SHIP_DIV8) ? DIV_BY8 : DIV_BY1;
		else if (wr_ok && avs_address == OFF_DIV && avs_byteenable[0])
			div_q <= avs_writedata[3:0];
	end

	// Sleep request pulse from software; only honoured while running
	always_ff @(posedge clk) begin
		if (!rstn)
			sleep_q <= 1'b0;
		else
			sleep_q <= wr_ok && avs_address == OFF_CTRL && avs_byteenable[0] && avs_writedata[0];
	end

	// Read data; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_ok) begin
			unique case (avs_address)
				OFF_TRIM:   rdata_q <= {24'h00_0000, trim_q};
				OFF_DIV:    rdata_q <= {28'h000_0000, div_q};
				OFF_STATUS: rdata_q <= {22'h00_0000, hold_q, rst_out_q, err, dly_q, srcsel_q, rstdis_q};
				default:    rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign avs_readdata = rdata_q;
	assign sys_reset_n  = rst_out_q;
	assign wake_hold    = hold_q;
	assign src_sel      = 3'(src_q);
	assign rc_trim      = trim_q;
	assign div_code     = div_q;
	assign cfg_error    = err;

	AST_LFX_SEL: assert property (@(posedge clk) disable iff (!rstn)
		(srcsel_q == SEL_LFX_LO || srcsel_q == SEL_LFX_HI) |-> src_sel == 3'(SRC_LFXTAL))
		else $error("crystal code did not pick crystal");

	AST_RC_SEL: assert property (@(posedge clk) disable iff (!rstn)
		srcsel_q == SEL_RC |-> src_sel == 3'(SRC_RC) && src_tick == rc_rise)
		else $error("rc code did not pick rc");

	AST_LF128_SEL: assert property (@(posedge clk) disable iff (!rstn)
		srcsel_q == SEL_LF128 |-> src_sel == 3'(SRC_LF128) && src_tick == lf128_rise)
		else $error("128k code did not pick 128k");

	AST_EXT_SEL: assert property (@(posedge clk) disable iff (!rstn)
		srcsel_q == SEL_EXT |-> src_sel == 3'(SRC_EXT) && src_tick == xtal_rise)
		else $error("external code did not pick pin");

	AST_TRIM_LOAD: assert property (@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> rc_trim == $past(factory_trim))
		else $error("trim not loaded at reset");

	AST_TRIM_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && avs_address == OFF_TRIM && avs_byteenable[0]) |=> rc_trim == $past(avs_writedata[7:0]))
		else $error("trim write lost");

	AST_POR_COUNT: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == ST_POR_CK && !err) ##1 (state_q != ST_POR_CK) |-> $past(src_count) == ck_target)
		else $error("reset left before source count");

	AST_MS_COUNT: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == ST_POR_MS) ##1 (state_q == ST_RUN) |-> $past(wd_count) == ms_target)
		else $error("time-out ended early");

	AST_WAKE_COUNT: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == ST_WAKE) ##1 (state_q == ST_RUN) |-> $past(src_count) == wake_target)
		else $error("wake left before source count");

	AST_RSTDIS_EXT: assert property (@(posedge clk) disable iff (!rstn)
		(rstdis_q && dly_q == DLY_SHORT && src_q == SRC_RC) |-> ms_target == MS_4P1_TICKS)
		else $error("reset pin disable delay missing");

	AST_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
		$rose(sys_reset_n) |-> $past(state_q, 2) == ST_POR_CK || $past(state_q, 2) == ST_POR_MS)
		else $error("reset released outside sequence");

endmodule // ccs_clock_select

// >>> ccs_osc_model.sv
`timescale 1ns/1ps
module ccs_osc_model #(
	parameter int XT_HALF = 30,
	parameter int RC_HALF = 30,
	parameter int LF_HALF = 35,
	parameter int WD_HALF = 40
) (
	// Source and watchdog oscillators
	output logic crystal_input_pin,
	output logic rc_osc_clk,
	output logic lf128_osc_clk,
	output logic wdog_osc_clk
);
	// Steady periods: no cycle-to-cycle drift, each level at least three system clocks
	initial begin
		crystal_input_pin = 1'b0;
		#3 forever #XT_HALF crystal_input_pin = ~crystal_input_pin;
	end
	initial begin
		rc_osc_clk = 1'b0;
		#7 forever #RC_HALF rc_osc_clk = ~rc_osc_clk;
	end
	initial begin
		lf128_osc_clk = 1'b0;
		#2 forever #LF_HALF lf128_osc_clk = ~lf128_osc_clk;
	end
	// Watchdog runs apart from the selected source
	initial begin
		wdog_osc_clk = 1'b0;
		#4 forever #WD_HALF wdog_osc_clk = ~wdog_osc_clk;
	end
endmodule // ccs_osc_model

// >>> test_clock_source_startup_select.sv
`timescale 1ns/1ps
module test_clock_source_startup_select
	import ccs_pkg::*;
;
	localparam int M41 = 5;
	localparam int M65 = 6;
	localparam int M4  = 7;
	localparam int M64 = 8;
	logic        clk, rstn, fuse_valid, divide_by_eight_fuse, reset_pin_disable_fuse, wake_event;
	logic [3:0]  clock_source_select_fuses;
	logic [1:0]  startup_time_fuses;
	logic [7:0]  factory_trim, rc_trim;
	logic        crystal_input_pin, rc_osc_clk, lf128_osc_clk, wdog_osc_clk;
	logic [3:0]  avs_address, avs_byteenable, div_code;
	logic        avs_read, avs_write, avs_waitrequest, sys_reset_n, wake_hold, cfg_error, counting, src_w;
	logic [31:0] avs_writedata, avs_readdata, rd, d;
	logic [2:0]  src_sel;
	int          n_fail, total_checks, cyc, n_src, n_wd, ck_exp;

	ccs_clock_select #(.MS_4P1_TICKS(16'(M41)), .MS_65_TICKS(16'(M65)), .MS_4_TICKS(16'(M4)),
		.MS_64_TICKS(16'(M64))) dut (.clk, .rstn, .fuse_valid, .clock_source_select_fuses,
		.startup_time_fuses, .divide_by_eight_fuse, .reset_pin_disable_fuse, .factory_trim,
		.crystal_input_pin, .rc_osc_clk, .lf128_osc_clk, .wdog_osc_clk, .wake_event, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.sys_reset_n, .wake_hold, .src_sel, .rc_trim, .div_code, .cfg_error);
	ccs_osc_model osc (.crystal_input_pin, .rc_osc_clk, .lf128_osc_clk, .wdog_osc_clk);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	assign src_w = (!fuse_valid || clock_source_select_fuses == SEL_RC) ? rc_osc_clk :
		(clock_source_select_fuses == SEL_LF128) ? lf128_osc_clk : crystal_input_pin;
	always @(posedge src_w) if (counting) n_src++;
	always @(posedge wdog_osc_clk) if (counting && n_src >= ck_exp) n_wd++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic check(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	function automatic int ms_exp(input logic [3:0] s, input logic [1:0] u, input logic dis);
		if (u == DLY_SHORT) return (dis && (s == SEL_RC || s == SEL_LF128)) ? M41 : 0;
		if (u == DLY_MID) return (s == SEL_LF128) ? M4 : M41;
		return (s == SEL_LF128) ? M64 : M65;
	endfunction
	function automatic logic [2:0] src_exp(input logic [3:0] s);
		if (s == SEL_EXT) return 3'h0;
		if (s == SEL_RC) return 3'h1;
		if (s == SEL_LF128) return 3'h2;
		return 3'h3;
	endfunction
	// Ends one edge after release so the next call never drives the same step
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
		int t;
		t = 0;
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && t < 100) begin
			@(posedge clk);
			t++;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic start(input logic v, input logic [3:0] s, input logic [1:0] u, input logic dis, input logic bad);
		logic [3:0] es;
		logic [1:0] eu;
		int t, ms;
		fuse_valid <= v;
		clock_source_select_fuses <= s;
		startup_time_fuses <= u;
		divide_by_eight_fuse <= 1'($urandom);
		reset_pin_disable_fuse <= dis;
		factory_trim <= 8'($urandom);
		rstn <= 1'b0;
		repeat (8) @(posedge clk);
		es = v ? s : SHIP_SEL;
		eu = v ? u : SHIP_DLY;
		ms = ms_exp(es, eu, dis);
		check(rc_trim === factory_trim, "trim not loaded in reset");
		check(div_code === ((divide_by_eight_fuse || !v) ? DIV_BY8 : DIV_BY1), "divider reset code");
		check(sys_reset_n === 1'b0, "reset not held");
		ck_exp = (es[3:1] == 3'b011) ? 4 : 14;
		n_src = 0;
		n_wd = 0;
		counting = 1'b1;
		// Edges already inside the synchroniser at release are counted by the design
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		if (bad) begin
			repeat (300) @(posedge clk);
			check(cfg_error === 1'b1 && sys_reset_n === 1'b0, "reserved code released");
			return;
		end
		if (es != 4'hF) check(src_sel === src_exp(es), "source select");
		t = 0;
		while (sys_reset_n !== 1'b1 && t < 5000) begin
			@(posedge clk);
			t++;
		end
		counting = 1'b0;
		check(n_src >= ck_exp && (ms > 0 || n_src <= ck_exp + 2), "source cycles");
		check(n_wd >= ms && n_wd <= ms + 2, "time-out ticks");
	endtask
	task automatic sleep_wake(input int w);
		int t;
		t = 0;
		bus(1'b1, OFF_CTRL, 32'h00000001, 4'hF);
		while (wake_hold !== 1'b1 && t < 50) begin
			@(posedge clk);
			t++;
		end
		check(wake_hold === 1'b1, "sleep not entered");
		ck_exp = 1 << 30;
		n_src = 0;
		counting = 1'b1;
		wake_event <= 1'b1;
		repeat (4) @(posedge clk);
		wake_event <= 1'b0;
		t = 0;
		while (wake_hold !== 1'b0 && t < 20000) begin
			@(posedge clk);
			t++;
		end
		counting = 1'b0;
		check(n_src >= w && n_src <= w + 2, "wake-up cycles");
	endtask

	initial begin
		logic [3:0] srcs [4];
		{rstn, fuse_valid, divide_by_eight_fuse, reset_pin_disable_fuse, wake_event} = 5'h00;
		{clock_source_select_fuses, startup_time_fuses, factory_trim} = 14'h0000;
		{avs_address, avs_byteenable, avs_read, avs_write, avs_writedata} = 42'h0;
		{n_fail, total_checks, cyc, n_src, n_wd, ck_exp, counting} = '0;
		srcs = '{SEL_EXT, SEL_RC, SEL_LF128, SEL_LFX_LO};
		void'($urandom(2));
		foreach (srcs[i])
			for (int u = 0; u < 3; u++) start(1'b1, srcs[i], 2'(u), 1'b0, 1'b0);
		start(1'b1, SEL_LFX_HI, DLY_MID, 1'b0, 1'b0);
		start(1'b1, SEL_RC, DLY_SHORT, 1'b1, 1'b0);
		start(1'b1, SEL_LF128, DLY_SHORT, 1'b1, 1'b0);
		start(1'b0, 4'hF, DLY_RESERVED, 1'b0, 1'b0);
		start(1'b1, SEL_RC, DLY_RESERVED, 1'b0, 1'b1);
		start(1'b1, SEL_LFX_LO, DLY_RESERVED, 1'b0, 1'b1);
		start(1'b1, SEL_RC, DLY_SHORT, 1'b0, 1'b0);
		bus(1'b0, OFF_TRIM, 32'h0, 4'hF);
		check(rd === {24'h000000, factory_trim}, "trim readback");
		d = $urandom;
		bus(1'b1, OFF_TRIM, d, 4'hF);
		check(rc_trim === d[7:0], "trim write");
		bus(1'b1, OFF_TRIM, ~d, 4'hE);
		bus(0, OFF_TRIM, 32'h0, 4'hF);
		check(rd === {24'h000000, d[7:0]}, "masked trim write");
		bus(1'b0, OFF_STATUS, 32'h0, 4'hF);
		check(rd === {22'h0, 1'b0, 1'b1, 1'b0, DLY_SHORT, SEL_RC, 1'b0}, "status word");
		bus(1'b0, 4'h2, 32'h0, 4'hF);
		check(rd === 32'h00000000, "unmapped read");
		bus(1'b1, OFF_DIV, 32'h00000005, 4'hF);
		check(div_code === 4'h5, "divider write");
		sleep_wake(6);
		start(1'b1, SEL_LFX_LO, DLY_SHORT, 1'b0, 1'b0);
		sleep_wake(1024);
		print_verdict();
	end
endmodule // test_clock_source_startup_select
